// [asbi_defines.svh]
`ifndef ASBI_DEFINES_SVH
`define ASBI_DEFINES_SVH

// ----------------------------------------------------------------------
// clock and conversion
// ----------------------------------------------------------------------
`define ASBI_CLK_PERIOD_NS 25
// least times round up to whole cycles
`define ASBI_NS2CYC(ns) (((ns) + `ASBI_CLK_PERIOD_NS - 1) / `ASBI_CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// bus widths and synchroniser stages
// ----------------------------------------------------------------------
`define ASBI_ADDR_W 17
`define ASBI_DATA_W 8
`define ASBI_SYNC_STAGES 3

// ----------------------------------------------------------------------
// device timing in ns, fast and slow grade
// ----------------------------------------------------------------------
`define ASBI_ADDR_ACCESS_DELAY_FAST 55
`define ASBI_ADDR_ACCESS_DELAY_SLOW 70
`define ASBI_CYCLE_TIME_FAST 55
`define ASBI_CYCLE_TIME_SLOW 70
`define ASBI_SELECT_TO_WRITE_END_FAST 45
`define ASBI_SELECT_TO_WRITE_END_SLOW 60
`define ASBI_WADDR_SETUP_END_FAST 45
`define ASBI_WADDR_SETUP_END_SLOW 60
`define ASBI_STROBE_PULSE_MIN_FAST 45
`define ASBI_STROBE_PULSE_MIN_SLOW 50
`define ASBI_WDATA_SETUP_FAST 45
`define ASBI_WDATA_SETUP_SLOW 55

`endif

// [asbi_pkg.sv]
`include "asbi_defines.svh"

package asbi_pkg;

   // ----------------------------------------------------------------------
   // controller states
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WR_SETUP = 3'b001,
      ST_WR_PULSE = 3'b010,
      ST_WR_END = 3'b011,
      ST_RD_WAIT = 3'b100
   } asbi_state_e;

   // ----------------------------------------------------------------------
   // user request and memory pin group
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic write;
      logic [`ASBI_ADDR_W-1:0] addr;
      logic [`ASBI_DATA_W-1:0] wdata;
   } asbi_req_s;

   typedef struct packed {
      logic [`ASBI_ADDR_W-1:0] addr;
      logic selectActiveLowN;
      logic selectActiveHigh;
      logic gateN;
      logic strobeN;
   } asbi_pins_s;

endpackage : asbi_pkg

// [asbi_host.sv]
`timescale 1ns/10ps
`include "asbi_defines.svh"

// Operation
// R1 - read data valid 55/70 ns after select
// R2 - new read address gives data in 55/70
// R3 - old data held 5 ns after address change
// R4 - gate low gives data in 20/35 ns
// R5 - deselect reaches standby within 55/70 ns
// R6 - strobe stays high during every read
// R7 - address valid no later than select
// R8 - write needs both selects and strobe active
// R9 - any control leaving active ends write
// R10 - write data stable 45/55 before end
// R11 - address valid 45/60 before write end
// R12 - select 45/60 and strobe pulse 45/50
// R13 - gate high keeps lines released during write
// R14 - deselect with strobe rise stays released
// R15 - gate low: no drive until lines released
// R16 - lines released when deselected or disabled
// R17 - valid read drives the addressed byte
// R18 - array holds 131072 bytes, 17-bit address
// R19 - accesses spaced by the grade cycle time
module asbi_host #(
   parameter bit FAST_GRADE = 1'b1
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // user request
   input wire logic reqValid,
   input wire asbi_pkg::asbi_req_s req,
   output logic reqReady,
   // user read answer
   output logic rspValid,
   output logic [`ASBI_DATA_W-1:0] rspData,
   // memory control pins
   output asbi_pkg::asbi_pins_s pins,
   // memory data lines, three signals
   input wire logic [`ASBI_DATA_W-1:0] byteLinesIn,
   output logic [`ASBI_DATA_W-1:0] byteLinesOut,
   output logic byteLinesOe
);

   // ----------------------------------------------------------------------
   // timing in cycles
   // ----------------------------------------------------------------------
   localparam int ACC_NS = FAST_GRADE ? `ASBI_ADDR_ACCESS_DELAY_FAST : `ASBI_ADDR_ACCESS_DELAY_SLOW;
   localparam int CYC_NS = FAST_GRADE ? `ASBI_CYCLE_TIME_FAST : `ASBI_CYCLE_TIME_SLOW;
   localparam int SCE_NS = FAST_GRADE ? `ASBI_SELECT_TO_WRITE_END_FAST
                                      : `ASBI_SELECT_TO_WRITE_END_SLOW;
   localparam int AW_NS = FAST_GRADE ? `ASBI_WADDR_SETUP_END_FAST : `ASBI_WADDR_SETUP_END_SLOW;
   localparam int PWE_NS = FAST_GRADE ? `ASBI_STROBE_PULSE_MIN_FAST : `ASBI_STROBE_PULSE_MIN_SLOW;
   localparam int SD_NS = FAST_GRADE ? `ASBI_WDATA_SETUP_FAST : `ASBI_WDATA_SETUP_SLOW;
   localparam int ACC_CYC = `ASBI_NS2CYC(ACC_NS);
   localparam int CYC_CYC = `ASBI_NS2CYC(CYC_NS);
   localparam int SD_CYC = `ASBI_NS2CYC(SD_NS);
   localparam int PWE_CYC = `ASBI_NS2CYC(PWE_NS);
   localparam int SCE_CYC = `ASBI_NS2CYC(SCE_NS);
   localparam int AW_CYC = `ASBI_NS2CYC(AW_NS);
   // strobe low long enough for pulse, data, address and select set-up
   localparam int WR_A = (SD_CYC > PWE_CYC) ? SD_CYC : PWE_CYC;
   localparam int WR_B = (SCE_CYC > AW_CYC) ? SCE_CYC : AW_CYC;
   localparam int WR_CYC = (WR_A > WR_B) ? WR_A : WR_B;
   // read waits for access plus the input synchroniser delay
   localparam int RD_CYC = ACC_CYC + `ASBI_SYNC_STAGES;
   localparam logic [3:0] WR_LOAD = 4'(WR_CYC - 1);
   localparam logic [3:0] RD_LOAD = 4'(RD_CYC - 1);

   // refuse timings the 4-bit counter cannot hold
   if (RD_CYC > 15 || WR_CYC > 15 || RD_CYC < CYC_CYC) begin : g_bad_timing
      $error("asbi_host: timing does not fit the cycle counter");
   end

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   asbi_pkg::asbi_state_e state;
   logic [3:0] cnt;
   logic [`ASBI_DATA_W-1:0] sync1;
   logic [`ASBI_DATA_W-1:0] sync2;
   logic [`ASBI_DATA_W-1:0] sync3;
   logic accept;
   logic cntDone;
   logic syncAgree;
   logic rdFinish;

   assign accept = reqValid && reqReady;
   assign cntDone = (cnt == 4'h0);
   // a changing byte is taken only once two stages agree
   assign syncAgree = (sync2 == sync3);
   assign rdFinish = (state == asbi_pkg::ST_RD_WAIT) && cntDone && syncAgree;

   // three-stage synchroniser for the returning data lines
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1 <= 8'h00;
         sync2 <= 8'h00;
         sync3 <= 8'h00;
      end else begin
         sync1 <= byteLinesIn;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // ----------------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------------
   // state, cycle counter and request handshake
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= asbi_pkg::ST_IDLE;
         cnt <= 4'h0;
         reqReady <= 1'b0;
      end else begin
         unique case (state)
            asbi_pkg::ST_IDLE: begin
               reqReady <= !accept;
               if (accept) begin
                  state <= req.write ? asbi_pkg::ST_WR_SETUP : asbi_pkg::ST_RD_WAIT;
                  cnt <= req.write ? 4'h0 : RD_LOAD; // see R1
               end
            end
            asbi_pkg::ST_WR_SETUP: begin
               state <= asbi_pkg::ST_WR_PULSE;
               cnt <= WR_LOAD; // see R12
            end
            asbi_pkg::ST_WR_PULSE: begin
               if (cntDone) begin
                  state <= asbi_pkg::ST_WR_END;
               end else begin
                  cnt <= cnt - 4'h1;
               end
            end
            asbi_pkg::ST_WR_END: begin
               state <= asbi_pkg::ST_IDLE;
               reqReady <= 1'b1;
            end
            asbi_pkg::ST_RD_WAIT: begin
               if (rdFinish) begin
                  state <= asbi_pkg::ST_IDLE;
                  reqReady <= 1'b1;
               end else if (!cntDone) begin
                  cnt <= cnt - 4'h1;
               end
            end
            default: begin
               state <= asbi_pkg::ST_IDLE;
               reqReady <= 1'b1;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // memory pins
   // ----------------------------------------------------------------------
   // address and selects change on one edge, so address is never late
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pins.addr <= 17'h00000;
         pins.selectActiveLowN <= 1'b1;
         pins.selectActiveHigh <= 1'b0;
         pins.gateN <= 1'b1;
         pins.strobeN <= 1'b1;
      end else begin
         if (state == asbi_pkg::ST_IDLE && accept) begin
            pins.addr <= req.addr; // see R7
            pins.selectActiveLowN <= 1'b0;
            pins.selectActiveHigh <= 1'b1;
            pins.strobeN <= 1'b1; // see R6
            pins.gateN <= req.write; // gate high on writes, see R15
         end else if (state == asbi_pkg::ST_WR_SETUP) begin
            pins.strobeN <= 1'b0; // see R8
         end else if (state == asbi_pkg::ST_WR_PULSE && cntDone) begin
            pins.strobeN <= 1'b1; // strobe ends the write, see R10
         end else if (state == asbi_pkg::ST_WR_END || rdFinish) begin
            // deselect a cycle after strobe rise keeps address hold
            pins.selectActiveLowN <= 1'b1; // see R11
            pins.selectActiveHigh <= 1'b0;
            pins.gateN <= 1'b1;
         end
      end
   end

   // write data driven only while gate is high, so no contention
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         byteLinesOut <= 8'h00;
         byteLinesOe <= 1'b0;
      end else begin
         if (state == asbi_pkg::ST_IDLE && accept && req.write) begin
            byteLinesOut <= req.wdata; // see R10
            byteLinesOe <= 1'b1;
         end else if (state == asbi_pkg::ST_WR_END) begin
            byteLinesOe <= 1'b0;
         end
      end
   end

   // read answer, one-cycle pulse
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rspValid <= 1'b0;
         rspData <= 8'h00;
      end else begin
         rspValid <= rdFinish;
         if (rdFinish) begin
            rspData <= sync3;
         end
      end
   end

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   logic selected;
   logic [3:0] lowCnt;
   logic [3:0] selCnt;

   assign selected = !pins.selectActiveLowN && pins.selectActiveHigh;

   // helper counts of strobe-low and selected cycles, saturating
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lowCnt <= 4'h0;
         selCnt <= 4'h0;
      end else begin
         lowCnt <= pins.strobeN ? 4'h0 : ((lowCnt == 4'hF) ? lowCnt : lowCnt + 4'h1);
         selCnt <= !selected ? 4'h0 : ((selCnt == 4'hF) ? selCnt : selCnt + 4'h1);
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   sequence sWriteEnd;
      $rose(pins.strobeN) && selected;
   endsequence

   sequence sReadStart;
      $fell(pins.selectActiveLowN) && !pins.gateN;
   endsequence

   AST_READ_STROBE_HIGH: assert property (selected && !pins.gateN |-> pins.strobeN) // see R6
      else $error("strobe low during read");

   AST_ADDR_WITH_SELECT: assert property (sReadStart |-> pins.selectActiveHigh ##1
      ($stable(pins.addr) && selected)) // see R7
      else $error("address moved after select");

   AST_WRITE_START: assert property ($fell(pins.strobeN) |-> selected) // see R8
      else $error("write began without both selects");

   // lowCnt still holds the full low count in the cycle after the strobe rises
   AST_DATA_SETUP: assert property (sWriteEnd |-> byteLinesOe && $stable(byteLinesOut)
      && lowCnt >= 4'(SD_CYC)) // see R10
      else $error("write data set-up too short");

   AST_ADDR_HOLD: assert property (sWriteEnd |-> $stable(pins.addr) ##1
      $stable(pins.addr)) // see R11
      else $error("address changed at write end");

   AST_STROBE_PULSE: assert property (sWriteEnd |-> lowCnt >= 4'(PWE_CYC)
      && selCnt > 4'(SCE_CYC)) // see R12
      else $error("strobe pulse or select time too short");

   AST_NO_DRIVE_GATE_LOW: assert property (byteLinesOe |-> pins.gateN) // see R15
      else $error("data driven while gate low");

   AST_CYCLE_SPACING: assert property ($rose(pins.selectActiveLowN) |->
      $past(selCnt) >= 4'(CYC_CYC)) // see R19
      else $error("access shorter than cycle time");

   AST_READ_ANSWER: assert property (sReadStart |-> ##1 !rspValid [*2]) // see R1
      else $error("read answered before access time");

endmodule : asbi_host

// [asbi_sram_model.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// behavioural byte-wide static memory on the far side
// ----------------------------------------------------------------------
module asbi_sram_model #(
   parameter int ACCESS_NS = 55
) (
   // control pins from the host
   input wire asbi_pkg::asbi_pins_s pins,
   // resolved data lines in, own drive out
   input wire logic [7:0] byteBus,
   output logic [7:0] memDrive
);
   logic [7:0] mem [0:131071];
   logic [7:0] drv = 8'h00;
   logic [7:0] junk = 8'h5A;
   logic sel;
   logic readEn;
   logic writing;

   // either select inactive means standby and released lines
   assign sel = !pins.selectActiveLowN && pins.selectActiveHigh;
   assign readEn = sel && !pins.gateN && pins.strobeN;
   assign writing = sel && !pins.strobeN;
   // released lines float, so show a moving pattern, never the last byte
   always #13 junk = ~junk;
   // old byte held briefly, then garbage until the access delay runs out
   always @(pins.addr or readEn) begin
      drv <= #5 ~drv;
      if (readEn) drv <= #(ACCESS_NS) mem[pins.addr];
   end
   assign memDrive = readEn ? drv : junk;
   // byte stored when any of the three controls leaves its level
   always @(negedge writing) mem[pins.addr] = byteBus;
endmodule : asbi_sram_model

// [asbi_host_tb.sv]
`timescale 1ns/10ps
`include "asbi_defines.svh"
module asbi_host_tb;
   // ----------------------------------------------------------------------
   // connections and bookkeeping
   // ----------------------------------------------------------------------
   logic clk;
   logic reset_n;
   logic reqValid;
   asbi_pkg::asbi_req_s req;
   logic reqReady;
   logic rspValid;
   logic [7:0] rspData;
   asbi_pkg::asbi_pins_s pins;
   logic [7:0] byteLinesOut;
   logic byteLinesOe;
   logic [7:0] memDrive;
   logic [7:0] byteBus;
   int num_errors = 0;
   int samples_checked = 0;
   int cyc = 0;
   int strobeLen = 0;
   logic [7:0] expQ [$];
   int takeQ [$];
   logic [7:0] refMem [int];

   // host owns the lines only while its enable is high
   assign byteBus = byteLinesOe ? byteLinesOut : memDrive;

   asbi_host #(.FAST_GRADE(1'b1)) dut_u (.clk(clk), .reset_n(reset_n),
      .reqValid(reqValid), .req(req), .reqReady(reqReady), .rspValid(rspValid),
      .rspData(rspData), .pins(pins), .byteLinesIn(byteBus),
      .byteLinesOut(byteLinesOut), .byteLinesOe(byteLinesOe));
   asbi_sram_model #(.ACCESS_NS(55)) mem_u (.pins(pins), .byteBus(byteBus),
      .memDrive(memDrive));

   // ----------------------------------------------------------------------
   // compares and closing
   // ----------------------------------------------------------------------
   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_byte

   task automatic cmp_count(input int got, input int exp);
      samples_checked++;
      if (got != exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_count

   task automatic close_out();
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out

   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // hang guard, far beyond the few hundred cycles the run needs
   initial begin
      #(25 * 20000);
      num_errors++;
      close_out();
   end

   // ----------------------------------------------------------------------
   // watcher: pin rules every cycle, read answers against the oldest note
   // ----------------------------------------------------------------------
   always @(negedge clk) begin
      if (!reset_n) begin
         cmp_byte({pins.selectActiveLowN, pins.strobeN, byteLinesOe, reqReady}, 8'h0C);
      end else begin
         cyc++;
         if (!pins.selectActiveLowN && pins.selectActiveHigh && !pins.gateN) begin
            cmp_byte({7'h00, pins.strobeN}, 8'h01);
            cmp_byte({7'h00, byteLinesOe}, 8'h00);
         end
         if (byteLinesOe === 1'b1) cmp_byte({7'h00, pins.gateN}, 8'h01);
         if (pins.strobeN === 1'b0) begin
            strobeLen++;
            cmp_byte({pins.selectActiveLowN, pins.selectActiveHigh}, 8'h01);
         end else if (strobeLen != 0) begin
            cmp_count(strobeLen, `ASBI_NS2CYC(`ASBI_STROBE_PULSE_MIN_FAST));
            strobeLen = 0;
         end
         if (rspValid === 1'b1) begin
            cmp_byte(rspData, expQ.pop_front());
            // access cycles, three sync stages, then the registered answer
            cmp_count(int'((cyc - takeQ.pop_front()) >= (`ASBI_NS2CYC(
               `ASBI_ADDR_ACCESS_DELAY_FAST) + `ASBI_SYNC_STAGES + 1)), 1);
         end
      end
   end

   // ----------------------------------------------------------------------
   // driver: offer, hold until taken, note what should come back
   // ----------------------------------------------------------------------
   task automatic do_req(input logic wr, input logic [16:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      reqValid <= 1'b1;
      req <= '{wr, a, d};
      do @(negedge clk); while (reqReady !== 1'b1);
      @(posedge clk);
      reqValid <= 1'b0;
      if (wr) begin
         refMem[a] = d;
         do begin
            @(negedge clk);
            n++;
         end while (reqReady !== 1'b1);
         cmp_count(n, 5);
      end else begin
         expQ.push_back(refMem[a]);
         takeQ.push_back(cyc);
      end
   endtask : do_req

   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      logic [16:0] a;
      logic [7:0] d;
      int addrs [$];
      reset_n = 1'b0;
      reqValid = 1'b0;
      req = '0;
      void'($urandom(32'h97d4));
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      // array ends, and the top place overwritten from FF to A5, four of its bits changing
      do_req(1'b1, 17'h00000, 8'h3C);
      do_req(1'b1, 17'h1FFFF, 8'hFF);
      do_req(1'b1, 17'h1FFFF, 8'hA5);
      addrs = '{0, 17'h1FFFF};
      for (int i = 0; i < 20; i++) begin
         a = 17'($urandom);
         d = 8'($urandom);
         do_req(1'b1, a, d);
         addrs.push_back(int'(a));
      end
      // back-to-back reads while the previous one is still busy
      foreach (addrs[i]) do_req(1'b0, 17'(addrs[i]), 8'h00);
      // write then read straight after, alternating
      for (int i = 0; i < 16; i++) begin
         a = 17'($urandom);
         d = 8'($urandom);
         do_req(1'b1, a, d);
         do_req(1'b0, a, 8'h00);
      end
      repeat (20) @(posedge clk);
      // host reset in mid-run; memory contents must survive it
      reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      do_req(1'b0, 17'h1FFFF, 8'h00);
      repeat (20) @(posedge clk);
      cmp_count(expQ.size(), 0);
      close_out();
   end
endmodule : asbi_host_tb
